// ---- atfp_defines.vh ----
// Constants for the host port of the asynchronous transmit FIFO.
// Assumes byte addresses on an 8-bit host address bus.
`ifndef ATFP_DEFINES_VH
`define ATFP_DEFINES_VH
// ============================================================
// Port offsets
`define ATFP_OFF_FIRST 8'h80
`define ATFP_OFF_CONT 8'h84
`define ATFP_OFF_COMMIT 8'h8C
`define ATFP_OFF_RXDATA 8'hC0
// ============================================================
// Fields of the first quadlet, bit 31 is bit 0 on the bus
`define ATFP_SPD_HI 17
`define ATFP_SPD_LO 16
`define ATFP_RETRY_HI 9
`define ATFP_RETRY_LO 8
// ============================================================
// Speed and retry codes
`define ATFP_SPD_100 2'h0
`define ATFP_SPD_200 2'h1
`define ATFP_SPD_400 2'h2
`define ATFP_SPD_BAD 2'h3
`define ATFP_RT_NEW 2'h0
`define ATFP_RT_RETRY_X 2'h1
`define ATFP_RT_RETRY_A 2'h2
`define ATFP_RT_RETRY_B 2'h3
// ============================================================
// Word tags kept beside each queued quadlet
`define ATFP_TAG_FIRST 1
`define ATFP_TAG_LAST 0
// ============================================================
// Reset values
`define ATFP_RST_WORD 32'h00000000
`define ATFP_RST_EMPTY 1'h1
`define ATFP_RST_PEND 4'h0
`endif

// ---- atfp_top.v ----
// Host port of the asynchronous transmit FIFO and general receive FIFO.
// Assumes host bus and link side run on i_clk.
// Operation
// RULE1: Host writes first quadlet at first port
// RULE2: Host writes middle quadlets at continue port
// RULE3: Commit port write commits whole packet
// RULE4: Missing first quadlet makes transmitter stuck
// RULE5: Transmit FIFO underflow makes transmitter stuck
// RULE6: Stuck blocks async sends until FIFO clear
// RULE7: Isochronous sends still allowed while stuck
// RULE8: Commit with empty flag clears it, requests arbitration
// RULE9: Host loads packet in order, commits last
// RULE10: Host reads received data at data port
// RULE11: Async and iso data share receive FIFO
// RULE12: Port address marks begin, middle, end
// RULE13: Quadlet packet: control, address, optional data
// RULE14: Speed field selects 100, 200, 400 Mb/s
// RULE15: Retry field encodes new, X, A, B
// RULE16: Transaction label unique per outstanding transaction
// RULE17: Priority bits zero on cable bus
// RULE18: Destination is bus then node number
// RULE19: Destination offset quadlet aligned
// RULE20: Block packet fourth quadlet: length, extended code
// RULE21: No data quadlet for write response, read request
// RULE22: Data port read pops oldest quadlet
// RULE23: Clear bit empties FIFO, sets flag, unsticks
`timescale 1ns/1ps
`default_nettype none
`include "atfp_defines.vh"

// ============================================================
// Synchronous FIFO with flush
module atfp_fifo #(
	parameter W = 32,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire i_clk,
	input wire i_rst_b,
	input wire i_clr,
	input wire i_in_valid,
	output reg o_in_ready,
	input wire [W-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [W-1:0] o_out_data
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	reg [AW:0] cnt_d;
	reg out_valid_q;
	wire push;
	wire pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = out_valid_q && i_out_ready;
	assign o_out_valid = out_valid_q;
	assign o_out_data = mem[rd_q];

	always @* begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
		else if (pop && !push)
			cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
	end

	always @(posedge i_clk) begin
		if (push)
			mem[wr_q] <= i_in_data;
	end

	always @(posedge i_clk) begin
		if (!i_rst_b || i_clr) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			out_valid_q <= 1'b0;
			o_in_ready <= 1'b0;
		end else begin
			if (push)
				wr_q <= (wr_q == DEPTH-1) ? {AW{1'b0}} : wr_q + 1'b1;
			if (pop)
				rd_q <= (rd_q == DEPTH-1) ? {AW{1'b0}} : rd_q + 1'b1;
			cnt_q <= cnt_d;
			out_valid_q <= (cnt_d != {(AW+1){1'b0}});
			o_in_ready <= (cnt_d != DEPTH);
		end
	end
endmodule

// ============================================================
// Top: host port, transmit sequencer, receive path
module atfp_top #(
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire i_clk,
	input wire i_rst_b,
	input wire i_cs,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	output reg [31:0] o_rdata,
	output reg o_rvalid,
	output reg o_tx_fifo_ready,
	input wire i_tx_fifo_clear_bit,
	output reg o_tx_stuck_interrupt,
	output reg o_tx_fifo_empty_flag,
	output reg o_arb_req,
	output reg [31:0] o_tx_data,
	output reg o_tx_valid,
	output reg o_tx_first,
	output reg o_tx_last,
	input wire i_tx_ready,
	output reg [1:0] o_tx_speed,
	output reg [1:0] o_tx_retry,
	input wire i_iso_req,
	output reg o_iso_gnt,
	input wire i_rx_valid,
	input wire [31:0] i_rx_data,
	output reg o_rx_ready
);
	localparam S_IDLE = 2'b01;
	localparam S_SEND = 2'b10;

	reg [1:0] state_q;
	reg open_q;
	reg want_first_q;
	reg [AW:0] pend_q;
	reg [AW:0] pend_d;
	wire wr_first;
	wire wr_cont;
	wire wr_commit;
	wire rd_data;
	wire tx_in_ready;
	wire tx_out_valid;
	wire [33:0] tx_out;
	reg tx_pop;
	wire rx_in_ready;
	wire rx_out_valid;
	wire [31:0] rx_out;
	wire can_load;
	reg fault;
	reg done_pkt;

	// ============================================================
	// Port decode
	assign wr_first = i_cs && i_wr && (i_addr == `ATFP_OFF_FIRST); // RULE1
	assign wr_cont = i_cs && i_wr && (i_addr == `ATFP_OFF_CONT); // RULE2
	assign wr_commit = i_cs && i_wr && (i_addr == `ATFP_OFF_COMMIT); // RULE3
	assign rd_data = i_cs && i_rd && (i_addr == `ATFP_OFF_RXDATA); // RULE10

	// ============================================================
	// Transmit FIFO, each word tagged with its packet position
	atfp_fifo #(
		.W(34),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_tx_fifo (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_clr(i_tx_fifo_clear_bit), // RULE23
		.i_in_valid((wr_first || wr_cont || wr_commit) && open_ok(wr_first)),
		.o_in_ready(tx_in_ready),
		.i_in_data({wr_first, wr_commit, i_wdata}), // RULE12
		.o_out_valid(tx_out_valid),
		.i_out_ready(tx_pop),
		.o_out_data(tx_out)
	);

	// Words only queue when they belong to an opened packet
	function open_ok;
		input is_first;
		begin
			open_ok = is_first || open_q;
		end
	endfunction

	// ============================================================
	// General receive FIFO, shared by async and iso traffic
	atfp_fifo #(
		.W(32),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_rx_fifo (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_clr(1'b0),
		.i_in_valid(i_rx_valid), // RULE11
		.o_in_ready(rx_in_ready),
		.i_in_data(i_rx_data),
		.o_out_valid(rx_out_valid),
		.i_out_ready(rd_data), // RULE22
		.o_out_data(rx_out)
	);

	// ============================================================
	// Packet bookkeeping on the host side
	always @(posedge i_clk) begin
		if (!i_rst_b || i_tx_fifo_clear_bit) begin
			open_q <= 1'b0;
		end else if (wr_first && tx_in_ready) begin
			open_q <= 1'b1;
		end else if (wr_commit && tx_in_ready) begin
			open_q <= 1'b0;
		end
	end

	always @* begin
		pend_d = pend_q;
		if (wr_commit && open_q && tx_in_ready && !done_pkt)
			pend_d = pend_q + {{AW{1'b0}}, 1'b1}; // RULE3
		else if (done_pkt && !(wr_commit && open_q && tx_in_ready))
			pend_d = pend_q - {{AW{1'b0}}, 1'b1};
	end

	// ============================================================
	// Transmit sequencer
	assign can_load = !o_tx_valid || i_tx_ready;

	always @* begin
		tx_pop = 1'b0;
		fault = 1'b0;
		done_pkt = 1'b0;
		case (state_q)
			S_SEND: begin
				if (can_load && !o_tx_stuck_interrupt) begin
					if (!tx_out_valid) begin
						fault = 1'b1; // RULE5
					end else if (tx_out[32+`ATFP_TAG_FIRST] != want_first_q) begin
						fault = 1'b1; // RULE4
					end else begin
						tx_pop = 1'b1;
						done_pkt = tx_out[32+`ATFP_TAG_LAST];
					end
				end
			end
			default: begin
			end
		endcase
	end

	always @(posedge i_clk) begin
		if (!i_rst_b || i_tx_fifo_clear_bit) begin
			state_q <= S_IDLE;
			want_first_q <= 1'b1;
			pend_q <= `ATFP_RST_PEND;
			o_tx_data <= `ATFP_RST_WORD;
			o_tx_valid <= 1'b0;
			o_tx_first <= 1'b0;
			o_tx_last <= 1'b0;
			o_tx_speed <= `ATFP_SPD_100;
			o_tx_retry <= `ATFP_RT_NEW;
		end else begin
			pend_q <= pend_d;
			if (i_tx_ready)
				o_tx_valid <= 1'b0;
			case (state_q)
				S_IDLE: begin
					want_first_q <= 1'b1;
					if (pend_q != `ATFP_RST_PEND && !o_tx_stuck_interrupt)
						state_q <= S_SEND; // RULE6
				end
				S_SEND: begin
					if (fault) begin
						state_q <= S_IDLE;
					end else if (tx_pop) begin
						o_tx_data <= tx_out[31:0];
						o_tx_valid <= 1'b1;
						o_tx_first <= tx_out[32+`ATFP_TAG_FIRST];
						o_tx_last <= tx_out[32+`ATFP_TAG_LAST];
						want_first_q <= 1'b0;
						if (tx_out[32+`ATFP_TAG_FIRST]) begin
							o_tx_speed <= tx_out[`ATFP_SPD_HI:`ATFP_SPD_LO]; // RULE14
							o_tx_retry <= tx_out[`ATFP_RETRY_HI:`ATFP_RETRY_LO]; // RULE15
						end
						if (tx_out[32+`ATFP_TAG_LAST])
							state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// Stuck, empty flag and arbitration request
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_tx_stuck_interrupt <= 1'b0;
			o_tx_fifo_empty_flag <= `ATFP_RST_EMPTY;
			o_arb_req <= 1'b0;
		end else begin
			if (fault || ((wr_cont || wr_commit) && !open_q))
				o_tx_stuck_interrupt <= 1'b1; // RULE4
			else if (i_tx_fifo_clear_bit)
				o_tx_stuck_interrupt <= 1'b0; // RULE23
			o_arb_req <= 1'b0;
			if (wr_commit && open_q && tx_in_ready && !i_tx_fifo_clear_bit) begin
				o_tx_fifo_empty_flag <= 1'b0; // RULE8
				o_arb_req <= o_tx_fifo_empty_flag; // RULE8
			end else if (i_tx_fifo_clear_bit || pend_d == `ATFP_RST_PEND) begin
				o_tx_fifo_empty_flag <= 1'b1; // RULE23
			end
		end
	end

	// ============================================================
	// Host reads, ready flags, iso grant
	always @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rdata <= `ATFP_RST_WORD;
			o_rvalid <= 1'b0;
			o_tx_fifo_ready <= 1'b0;
			o_rx_ready <= 1'b0;
			o_iso_gnt <= 1'b0;
		end else begin
			o_rvalid <= i_cs && i_rd;
			if (rd_data && rx_out_valid)
				o_rdata <= rx_out; // RULE22
			else if (i_cs && i_rd)
				o_rdata <= `ATFP_RST_WORD;
			o_tx_fifo_ready <= tx_in_ready;
			o_rx_ready <= rx_in_ready;
			o_iso_gnt <= i_iso_req && !o_tx_valid; // RULE7
		end
	end
endmodule
`default_nettype wire

// ---- atfp_top_sva.sv ----
// Checker for the host port: bus, commit, stuck and clear behaviour.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module atfp_top_sva (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_cs,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic o_rvalid,
	input wire logic o_arb_req,
	input wire logic o_tx_fifo_empty_flag,
	input wire logic o_tx_stuck_interrupt,
	input wire logic i_tx_fifo_clear_bit,
	input wire logic o_tx_valid,
	input wire logic i_tx_ready,
	input wire logic [31:0] o_tx_data,
	input wire logic i_iso_req,
	input wire logic o_iso_gnt
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// ============================================================
	// Sequences
	sequence seq_flush;
		i_tx_fifo_clear_bit;
	endsequence
	sequence seq_stray;
		!i_tx_fifo_clear_bit && i_cs && i_wr && i_addr == 8'h84;
	endsequence
	// ============================================================
	// Assertions
	chk_read_answer: assert property (i_cs && i_rd |=> o_rvalid)
		else $error("read not answered");
	chk_read_quiet: assert property (!(i_cs && i_rd) |=> !o_rvalid)
		else $error("answer without read");
	chk_arb_pulse: assert property (o_arb_req |=> !o_arb_req)
		else $error("arbitration request too long");
	chk_arb_cause: assert property ($rose(o_arb_req) |->
		$past(i_cs && i_wr && i_addr == 8'h8C)) else $error("arb without commit");
	chk_arb_flag: assert property (o_arb_req |-> !o_tx_fifo_empty_flag)
		else $error("empty flag left set");
	chk_stuck_hold: assert property (o_tx_stuck_interrupt &&
		!i_tx_fifo_clear_bit |=> o_tx_stuck_interrupt) else $error("stuck lost");
	chk_stuck_quiet: assert property (o_tx_stuck_interrupt &&
		!o_tx_valid |=> !o_tx_valid) else $error("send while stuck");
	chk_clear_empties: assert property (i_tx_fifo_clear_bit |=>
		o_tx_fifo_empty_flag && !o_tx_valid) else $error("clear failed");
	chk_stray_stuck: assert property (seq_flush ##1 seq_stray |=>
		o_tx_stuck_interrupt) else $error("stray write not stuck");
	chk_iso_grant: assert property (i_iso_req && !o_tx_valid |=>
		o_iso_gnt) else $error("iso not granted");
	chk_tx_hold: assert property (o_tx_valid && !i_tx_ready &&
		!i_tx_fifo_clear_bit && !o_tx_stuck_interrupt |=>
		o_tx_valid && $stable(o_tx_data)) else $error("tx word dropped");
endmodule
bind atfp_top atfp_top_sva atfp_top_sva_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
	.o_rvalid(o_rvalid), .o_arb_req(o_arb_req),
	.o_tx_fifo_empty_flag(o_tx_fifo_empty_flag),
	.o_tx_stuck_interrupt(o_tx_stuck_interrupt),
	.i_tx_fifo_clear_bit(i_tx_fifo_clear_bit), .o_tx_valid(o_tx_valid),
	.i_tx_ready(i_tx_ready), .o_tx_data(o_tx_data),
	.i_iso_req(i_iso_req), .o_iso_gnt(o_iso_gnt));
`default_nettype wire

// ---- atfp_link_model.sv ----
// Link-side model: takes tx quadlets, feeds rx quadlets.
// Assumes the host port clock.
`timescale 1ns/1ps
`default_nettype none
module atfp_link_model (
	input wire logic i_clk,
	input wire logic i_slow,
	input wire logic [31:0] i_tx_data,
	input wire logic i_tx_valid,
	input wire logic i_tx_first,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [31:0] o_rx_data,
	input wire logic i_rx_ready
);
	logic [33:0] got[$];
	initial begin
		o_tx_ready = 1'b1;
		o_rx_valid = 1'b0;
		o_rx_data = 32'h0;
	end
	// Sink, stalls every other cycle when slow
	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready)
			got.push_back({i_tx_first, i_tx_last, i_tx_data});
		o_tx_ready <= !i_slow || !o_tx_ready;
	end
	// Source, holds valid until taken
	task automatic push(input logic [31:0] d);
		@(posedge i_clk);
		o_rx_valid <= 1'b1;
		o_rx_data <= d;
		do @(posedge i_clk); while (!i_rx_ready);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~d;
	endtask
endmodule
`default_nettype wire

// ---- atfp_top_tb_top.sv ----
// Testbench: host writes and reads against the link model.
// Assumes one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module atfp_top_tb_top;
	logic clk = 0, rst_b = 0, cs = 0, we = 0, re = 0, clr = 0;
	logic iso = 0, slow = 0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, txd, rxd, q, d2, d3, lq;
	logic rvalid, rdy, stuck, empty, arb, txv, txf, txl, txr, gnt, rxv, rxr;
	logic [1:0] spd, rty, sp;
	int num_errors = 0, n_checks = 0;
	always #2.5 clk = ~clk;
	atfp_top atfp_top_i (.i_clk(clk), .i_rst_b(rst_b), .i_cs(cs),
		.i_wr(we), .i_rd(re), .i_addr(addr), .i_wdata(wdata),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_tx_fifo_ready(rdy),
		.i_tx_fifo_clear_bit(clr), .o_tx_stuck_interrupt(stuck),
		.o_tx_fifo_empty_flag(empty), .o_arb_req(arb), .o_tx_data(txd),
		.o_tx_valid(txv), .o_tx_first(txf), .o_tx_last(txl),
		.i_tx_ready(txr), .o_tx_speed(spd), .o_tx_retry(rty),
		.i_iso_req(iso), .o_iso_gnt(gnt), .i_rx_valid(rxv),
		.i_rx_data(rxd), .o_rx_ready(rxr));
	atfp_link_model atfp_link_model_i (.i_clk(clk), .i_slow(slow),
		.i_tx_data(txd), .i_tx_valid(txv), .i_tx_first(txf),
		.i_tx_last(txl), .o_tx_ready(txr), .o_rx_valid(rxv),
		.o_rx_data(rxd), .i_rx_ready(rxr));
	// ============================================================
	// Tasks
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		n_checks++;
		if (g !== e) begin
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
			num_errors++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		clr <= 1'b0;
		cs <= 1'b1;
		we <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		cs <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		cs <= 1'b1;
		re <= 1'b1;
		addr <= a;
		@(posedge clk);
		cs <= 1'b0;
		re <= 1'b0;
		#1;
		chk(rvalid, 1);
		chk(rdata, e);
	endtask
	task automatic tally_and_finish;
		$display("errors=%0d checks=%0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ============================================================
	// Watchdog
	initial begin
		#20000;
		num_errors++;
		tally_and_finish;
	end
	// ============================================================
	// Tests
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(empty, 1);
		chk(stuck, 0);
		chk(rdy, 1);
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			atfp_link_model_i.got.delete();
			sp = (i == 3) ? 2'h2 : i[1:0];
			q = {14'h0, sp, 6'h0, i[1:0], 8'h00};
			q[15:10] = 6'h20 + i[5:0];
			q[7:4] = i[1] ? 4'h1 : 4'h4;
			d2 = 32'hFFC0_0000 + i;
			d3 = 32'h40 * i;
			lq = i[1] ? 32'hDA7A_0000 + i : d3;
			wr(8'h80, q);
			wr(8'h84, d2);
			if (i[1]) begin
				wr(8'h84, d3);
				wr(8'h84, 32'h0004_0000);
			end
			wr(8'h8C, lq);
			#1;
			chk(arb, 1);
			chk(empty, 0);
			for (int k = 0; k < 9 && !txv; k++) @(posedge clk);
			#1;
			chk(spd, sp);
			chk(rty, i[1:0]);
			for (int k = 0; k < 40; k++) @(posedge clk);
			chk(atfp_link_model_i.got.size(), 3 + 2 * i[1]);
			chk(atfp_link_model_i.got[0], {2'b10, q});
			chk(atfp_link_model_i.got[1], {2'b00, d2});
			chk(atfp_link_model_i.got[2 + 2 * i[1]], {2'b01, lq});
		end
		atfp_link_model_i.got.delete();
		@(posedge clk);
		clr <= 1'b1;
		wr(8'h84, 32'h5);
		@(posedge clk);
		#1;
		chk(stuck, 1);
		wr(8'h80, 32'h0);
		wr(8'h8C, 32'h0);
		iso <= 1'b1;
		repeat (20) @(posedge clk);
		#1;
		chk(atfp_link_model_i.got.size(), 0);
		chk(gnt, 1);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		iso <= 1'b0;
		repeat (10) @(posedge clk);
		#1;
		chk(stuck, 0);
		chk(empty, 1);
		chk(atfp_link_model_i.got.size(), 0);
		atfp_link_model_i.push(32'h1111_AAAA);
		atfp_link_model_i.push(32'h2222_5555);
		rd(8'hC0, 32'h1111_AAAA);
		rd(8'hC0, 32'h2222_5555);
		rd(8'hC0, 32'h0);
		rd(8'h88, 32'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
